// ==== shared/monitor_regs_pkg.sv ====
/*
 Package for the monitor configuration and first limit status registers:
 word offsets on the register bus, field positions, reset values and carrier structs.
 Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`default_nettype none
package monitor_regs_pkg;
    // Printed offsets are not word multiples, so each is an index; byte address = 4 * index
    localparam logic [7:0] CFG_ONE_IDX = 8'h40;
    localparam logic [7:0] STATUS_ONE_IDX = 8'h41;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h50;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h51;
    localparam logic [7:0] STATUS_TWO_IDX = 8'h42;

    localparam int GO_BIT = 0;
    localparam int LOCK_BIT = 1;
    localparam int READY_BIT = 2;
    localparam int FULL_BIT = 3;
    localparam int POWER_BIT = 4;
    localparam int BYPASS_BIT = 5;
    localparam int TIMEOUT_BIT = 6;
    localparam int RESCALE_BIT = 7;
    localparam int SUMMARY_BIT = 7;

    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Number of limit channels latched in the first status register
    localparam int NUM_CHAN = 7;
    // Power-up settle time before the ready flag rises
    localparam int READY_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int READY_CYCLES = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Interrupt status: bit 0 limit event latched, bit 1 ready reached
    localparam int IRQ_LIMIT_BIT = 0;
    localparam int IRQ_READY_BIT = 1;

    typedef struct packed {
        logic [NUM_CHAN-1:0] done;
        logic [NUM_CHAN-1:0] out_of_limit;
    } meas_result_t;

    typedef struct packed {
        logic monitor_go;
        logic use_defaults;
        logic all_fans_full;
        logic spinup_bypass;
        logic bus_timeout_off;
        logic supply_is_5v;
        logic power_calc_valid;
        logic locked;
    } monitor_ctrl_t;
endpackage
`default_nettype wire

// ==== design/monitor_config_status_regs.sv ====
/*
 Configuration register one and limit status register one of a hardware monitor,
 with a small interrupt pair, reached over a classic Wishbone slave.
 Assumes measurement results arrive as one-cycle done strobes with a compare result,
 and the second status register contents come from outside as a level vector.
*/
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module monitor_config_status_regs
    import monitor_regs_pkg::*;
#(
    parameter int READY_WAIT = READY_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire meas_result_t meas_i,
    input wire logic [7:0] status_two_i,
    output monitor_ctrl_t ctrl_o,
    output logic irq_o
);
    logic [7:0] cfg_q;
    logic [NUM_CHAN-1:0] stat_q;
    logic [NUM_CHAN-1:0] cond_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic ready_q;
    logic [$clog2(READY_WAIT+1)-1:0] ready_cnt_q;
    logic ack_q;
    logic [31:0] rdata_q;

    logic req;
    logic [7:0] idx;
    logic wr;
    logic rd;
    logic lane0;
    logic [7:0] wbyte;
    logic [NUM_CHAN-1:0] hit;
    logic status_read;
    logic limit_event;
    logic ready_rise;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign idx = wb_adr_i[9:2];
    assign lane0 = wb_sel_i[0];
    assign wr = req && wb_we_i && lane0;
    assign rd = req && !wb_we_i;
    assign wbyte = wb_dat_i[7:0];
    assign status_read = rd && idx == STATUS_ONE_IDX;

    // One-cycle answer, registered; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            case (idx)
                CFG_ONE_IDX: rdata_q <= {24'h00_0000, cfg_q[7:3], ready_q, cfg_q[1:0]};
                STATUS_ONE_IDX: rdata_q <= {24'h00_0000, |status_two_i, stat_q};
                STATUS_TWO_IDX: rdata_q <= {24'h00_0000, status_two_i};
                IRQ_MASK_IDX: rdata_q <= {30'h0000_0000, irq_mask_q};
                IRQ_STATUS_IDX: rdata_q <= {30'h0000_0000, irq_stat_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;

    // Lock freezes lockable bits; only a reset (power cycle) releases it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RESET;
        end else if (wr && idx == CFG_ONE_IDX) begin
            cfg_q[FULL_BIT] <= wbyte[FULL_BIT];
            cfg_q[BYPASS_BIT] <= wbyte[BYPASS_BIT];
            if (!cfg_q[LOCK_BIT]) begin
                cfg_q[GO_BIT] <= wbyte[GO_BIT];
                cfg_q[LOCK_BIT] <= wbyte[LOCK_BIT];
                cfg_q[POWER_BIT] <= wbyte[POWER_BIT];
                cfg_q[TIMEOUT_BIT] <= wbyte[TIMEOUT_BIT];
                cfg_q[RESCALE_BIT] <= wbyte[RESCALE_BIT];
            end
        end
    end

    // Go enables status latching and selects which limit set the datapath uses; stored limits are untouched
    always_comb begin
        ctrl_o.monitor_go = cfg_q[GO_BIT];
        ctrl_o.use_defaults = !cfg_q[GO_BIT];
        ctrl_o.all_fans_full = cfg_q[FULL_BIT];
        ctrl_o.spinup_bypass = cfg_q[BYPASS_BIT];
        ctrl_o.bus_timeout_off = cfg_q[TIMEOUT_BIT];
        ctrl_o.supply_is_5v = cfg_q[RESCALE_BIT];
        ctrl_o.power_calc_valid = cfg_q[POWER_BIT];
        ctrl_o.locked = cfg_q[LOCK_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            if (ready_cnt_q == ($clog2(READY_WAIT+1))'(READY_WAIT - 1)) begin
                ready_q <= 1'b1;
            end
            ready_cnt_q <= ready_cnt_q + 1'b1;
        end
    end
    assign ready_rise = !ready_q && ready_cnt_q == ($clog2(READY_WAIT+1))'(READY_WAIT - 1);

    // Per-channel latch; a new violation wins over a clearing read
    assign hit = meas_i.done & meas_i.out_of_limit & {NUM_CHAN{cfg_q[GO_BIT]}};
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : chan
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cond_q[g] <= 1'b0;
                    stat_q[g] <= STATUS_RESET[g];
                end else begin
                    if (meas_i.done[g] && cfg_q[GO_BIT]) begin
                        cond_q[g] <= meas_i.out_of_limit[g];
                    end
                    if (hit[g]) begin
                        stat_q[g] <= 1'b1;
                    end else if (status_read && !cond_q[g]) begin
                        stat_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign limit_event = |hit;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= MASK_RESET[1:0];
        end else begin
            if (wr && idx == IRQ_MASK_IDX) begin
                irq_mask_q <= wbyte[1:0];
            end
            irq_stat_q[IRQ_LIMIT_BIT] <= limit_event
                || (irq_stat_q[IRQ_LIMIT_BIT]
                && !(wr && idx == IRQ_STATUS_IDX && wbyte[IRQ_LIMIT_BIT]));
            irq_stat_q[IRQ_READY_BIT] <= ready_rise
                || (irq_stat_q[IRQ_READY_BIT]
                && !(wr && idx == IRQ_STATUS_IDX && wbyte[IRQ_READY_BIT]));
        end
    end
    assign irq_o = |(irq_stat_q & irq_mask_q);

    cfg_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q[LOCK_BIT] |=> $stable(cfg_q[GO_BIT]) && cfg_q[LOCK_BIT])
        else $error("go or lock changed while locked");
    lock_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q[LOCK_BIT] |=> $stable({cfg_q[7:6], cfg_q[4]}))
        else $error("lockable field changed while locked");
    full_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX |=> ctrl_o.all_fans_full == $past(wbyte[FULL_BIT]))
        else $error("full-speed bit not written");
    // Cycles since reset release, saturating, so the ready delay can be checked at any length
    localparam int UP_W = $clog2(READY_WAIT + 1) + 1;
    logic [UP_W-1:0] up_cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_cnt_q <= '0;
        end else if (up_cnt_q != UP_W'(READY_WAIT)) begin
            up_cnt_q <= up_cnt_q + 1'b1;
        end
    end

    ready_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ready_q) |-> up_cnt_q == UP_W'(READY_WAIT))
        else $error("ready rose at the wrong time");
    status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hit[0] |=> stat_q[0])
        else $error("voltage status bit not latched");
    temp_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hit[5] |=> stat_q[5])
        else $error("temperature status bit not latched");
    read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_read && cond_q[2] |=> stat_q[2] == $past(stat_q[2]) || $past(hit[2]))
        else $error("status cleared while condition holds");
    idle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg_q[GO_BIT] && !stat_q[1] |=> !stat_q[1])
        else $error("status set while monitoring stopped");
    defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX && !cfg_q[LOCK_BIT] |=>
        ctrl_o.monitor_go == $past(wbyte[GO_BIT]) && ctrl_o.use_defaults == !$past(wbyte[GO_BIT]))
        else $error("go write not applied to limit select");

    ready_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
        up_cnt_q < UP_W'(READY_WAIT) |-> !ready_q)
        else $error("ready high before settle time");

    ready_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_q |=> ready_q)
        else $error("ready flag dropped");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ack_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");

    upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");

    summary_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_read |=> wb_dat_o[SUMMARY_BIT] == $past(|status_two_i))
        else $error("summary bit not OR of status two");

    status_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_read |=> wb_dat_o[6:0] == $past(stat_q))
        else $error("status read data wrong");

    clear_gone_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_read && !cond_q[0] && !hit[0] |=> !stat_q[0])
        else $error("status not cleared after condition gone");

    bypass_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX |=> ctrl_o.spinup_bypass == $past(wbyte[BYPASS_BIT]))
        else $error("bypass bit not written");

    timeout_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX && !cfg_q[LOCK_BIT] |=>
        ctrl_o.bus_timeout_off == $past(wbyte[TIMEOUT_BIT]))
        else $error("timeout bit not written");

    rescale_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX && !cfg_q[LOCK_BIT] |=>
        ctrl_o.supply_is_5v == $past(wbyte[RESCALE_BIT]))
        else $error("rescale bit not written");

    power_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == CFG_ONE_IDX && !cfg_q[LOCK_BIT] |=>
        ctrl_o.power_calc_valid == $past(wbyte[POWER_BIT]))
        else $error("power flag not written");

    irq_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        limit_event |=> irq_stat_q[IRQ_LIMIT_BIT])
        else $error("limit interrupt not latched");
endmodule
`default_nettype wire

// ==== verif/meas_source_model.sv ====
/*
 Measurement source model: a one-cycle done pulse per channel with its compare result.
 Assumes the bench asks for a pulse by holding pulse_i high for one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module meas_source_model
    import monitor_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic pulse_i,
    input wire logic [2:0] chan_i,
    input wire logic bad_i,
    output meas_result_t meas_o
);
    initial meas_o = '0;
    // The compare result means nothing without done, so it drops with it
    always @(posedge clk_i) begin
        meas_result_t nxt;
        nxt = '0;
        if (pulse_i) begin
            nxt.done[chan_i] = 1'b1;
            nxt.out_of_limit[chan_i] = bad_i;
        end
        meas_o <= nxt;
    end
endmodule
`default_nettype wire

// ==== verif/monitor_config_status_regs_tb.sv ====
/*
 Self-checking bench for the configuration and limit status registers.
 Assumes a 4 ns clock; measurement pulses come from the source model.
*/
`timescale 1ns/1ps
`default_nettype none
module monitor_config_status_regs_tb;
    import monitor_regs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [3:0] sel = '0;
    logic [31:0] rdat;
    logic ack;
    logic pulse = 1'b0;
    logic [2:0] chan = '0;
    logic bad = 1'b0;
    logic [7:0] st_two = '0;
    meas_result_t meas;
    monitor_ctrl_t ctrl;
    logic irq;
    logic [7:0] q;
    logic [7:0] cfg;
    logic [7:0] w;
    int err_total = 0;
    int n_tests = 0;

    always #2 clk_i = ~clk_i;
    meas_source_model meas_source_model_inst (.clk_i(clk_i), .pulse_i(pulse), .chan_i(chan),
        .bad_i(bad), .meas_o(meas));
    monitor_config_status_regs #(.READY_WAIT(4)) monitor_config_status_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .meas_i(meas), .status_two_i(st_two), .ctrl_o(ctrl), .irq_o(irq));

    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release for a cycle
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            conclude();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
    endtask

    task automatic fire(input logic [2:0] ch, input logic b);
        @(posedge clk_i);
        pulse <= 1'b1;
        chan <= ch;
        bad <= b;
        @(posedge clk_i);
        pulse <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    function automatic logic [7:0] cfg_next(input logic [7:0] old, input logic [7:0] wv);
        logic [7:0] keep;
        keep = old[LOCK_BIT] ? 8'hD7 : 8'h04;
        return (old & keep) | (wv & ~keep & 8'hFB) | 8'h04;
    endfunction

    function automatic monitor_ctrl_t ctrl_exp(input logic [7:0] c);
        return '{c[GO_BIT], !c[GO_BIT], c[FULL_BIT], c[BYPASS_BIT], c[TIMEOUT_BIT],
                 c[RESCALE_BIT], c[POWER_BIT], c[LOCK_BIT]};
    endfunction

    task automatic cfg_wr_chk(input logic [7:0] wv);
        bus(1'b1, CFG_ONE_IDX, wv, 4'hF);
        cfg = cfg_next(cfg, wv);
        bus(1'b0, CFG_ONE_IDX, 8'h00, 4'hF);
        chk(q, cfg);
        chk(ctrl, ctrl_exp(cfg));
    endtask

    task automatic st_chk(input logic [7:0] exp);
        bus(1'b0, STATUS_ONE_IDX, 8'h00, 4'hF);
        chk(q, exp);
    endtask

    initial begin
        void'($urandom(32'hB7EED526));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        cfg = 8'h04;
        cfg_wr_chk(8'h00);
        fire(3'd0, 1'b1);
        st_chk(8'h00);
        repeat (6) cfg_wr_chk(8'($urandom) & 8'hFD);
        cfg_wr_chk(8'h01);
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            fire(3'(ch), 1'b1);
            st_chk(8'h01 << ch);
            st_chk(8'h01 << ch);
            fire(3'(ch), 1'b0);
            st_chk(8'h01 << ch);
            st_chk(8'h00);
        end
        w = 8'($urandom) | 8'h01;
        st_two <= w;
        st_chk(8'h80);
        bus(1'b0, STATUS_TWO_IDX, 8'h00, 4'hF);
        chk(q, w);
        st_two <= 8'h00;
        st_chk(8'h00);
        bus(1'b1, IRQ_STATUS_IDX, 8'h03, 4'hF);
        bus(1'b1, IRQ_MASK_IDX, 8'h01, 4'hF);
        fire(3'd2, 1'b1);
        chk(irq, 1'b1);
        bus(1'b1, IRQ_MASK_IDX, 8'h02, 4'h0);
        bus(1'b0, IRQ_MASK_IDX, 8'h00, 4'hF);
        chk(q, 8'h01);
        bus(1'b1, IRQ_STATUS_IDX, 8'h01, 4'hF);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        bus(1'b1, 8'h7F, 8'hFF, 4'hF);
        bus(1'b0, 8'h7F, 8'h00, 4'hF);
        chk(q, 8'h00);
        cfg_wr_chk(8'($urandom) | 8'h02);
        cfg_wr_chk(~cfg);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        cfg = 8'h04;
        cfg_wr_chk(8'h00);
        conclude();
    end

    initial begin
        repeat (50000) @(posedge clk_i);
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
